// File: cell_link_pkg.sv
// shared constants, types and states for the cell link port
package cell_link_pkg;
    localparam int         CELL_OCTETS   = 53;
    localparam logic [5:0] CELL_FIRST    = 6'h00;
    localparam logic [5:0] CELL_LAST     = 6'h34;
    localparam logic [5:0] IDLE_PTI_IDX  = 6'h03;
    localparam logic [5:0] IDLE_HEC_IDX  = 6'h04;
    localparam logic [7:0] IDLE_HDR_ZERO = 8'h00;
    localparam logic [7:0] IDLE_HDR_LAST = 8'h01;
    localparam logic [7:0] IDLE_HEC      = 8'h52;
    localparam logic [7:0] IDLE_FILL     = 8'h6a;
    localparam int         RX_PIPE_LEN   = 3;

    typedef struct packed {
        logic       soc;
        logic [7:0] octet;
    } cell_byte_t;

    typedef enum logic [2:0] {
        TX_OFF       = 3'b001,
        TX_IDLE_CELL = 3'b010,
        TX_USER_CELL = 3'b100
    } tx_state_t;
endpackage

// File: cell_link_port.sv
// cell link port: utopia receive handshakes, transmit cells, mii receive status
`timescale 1ns/10ps
// Summary of operation
// R1: as slave, start-of-cell marks only the first driven octet of each cell.
// R2: as slave, cell-available output is high while a complete cell is stored.
// R3: as master, the far side raises cell-available when it holds a complete cell.
// R4: transmit octets leave on eight lines, bit zero least significant.
// R5: with no queued cell, idle cells are sent instead.
// R6: every cell, idle cells included, is exactly 53 octets.
// R7: mii phy holds receive valid high while presenting valid data.
// R8: carrier sense without receive valid is flagged as a broken header.
// R9: mii phy raises receive error to report a bad frame.
// R10: data and start-of-cell are driven in the cycle after an enable cycle; as slave, start-of-cell is driven in every cycle while slave_on.
// R11: mii phy raises carrier sense while the cable is active.
// R12: after reset, handshake outputs are low and transmit idles until enabled.
module cell_link_port #(
    parameter int CELL_LEN = cell_link_pkg::CELL_OCTETS
) (
    input  wire logic                     mclk_i,
    input  wire logic                     reset_n_i,
    input  wire logic                     chan_enable_i,
    input  wire logic                     utopia_slave_i,
    input  wire logic                     mii_mode_i,
    input  wire cell_link_pkg::cell_byte_t cell_load_i,
    input  wire logic                     cell_load_valid_i,
    output logic                          cell_load_ready_o,
    output cell_link_pkg::cell_byte_t     cell_recv_o,
    output logic                          cell_recv_valid_o,
    input  wire logic                     rxenb_pin_i,
    output logic                          rxenb_o,
    output logic                          rxenb_oe_o,
    input  wire logic                     rxclav_pin_i,
    output logic                          rxclav_o,
    output logic                          rxclav_oe_o,
    input  wire logic [7:0]               rxd_pin_i,
    output logic [7:0]                    rxd_o,
    output logic                          rxd_oe_o,
    input  wire logic                     rxsoc_pin_i,
    output logic                          rxsoc_o,
    output logic                          rxsoc_oe_o,
    input  wire logic [7:0]               tx_byte_i,
    input  wire logic                     tx_valid_i,
    output logic                          tx_ready_o,
    output logic [7:0]                    txd_o,
    output logic                          txsoc_o,
    output logic                          txenb_o,
    input  wire logic                     crs_pin_i,
    input  wire logic                     rx_dv_pin_i,
    input  wire logic                     rx_er_pin_i,
    output logic                          mii_rx_valid_o,
    output logic                          mii_rx_error_o,
    output logic                          mii_broken_header_o
);
    import cell_link_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic [12:0] sync1_reg;
    logic [12:0] sync2_reg;
    wire  [12:0] pins_raw = {crs_pin_i, rx_dv_pin_i, rx_er_pin_i, rxsoc_pin_i,
                             rxd_pin_i, rxenb_pin_i};
    always_ff @(posedge mclk_i) begin
        sync1_reg <= pins_raw;
        sync2_reg <= sync1_reg;
    end
    wire       rxenb_sync = sync2_reg[0];
    wire [7:0] rxd_sync   = sync2_reg[8:1];
    wire       soc_sync   = sync2_reg[9];
    wire       er_sync    = sync2_reg[10];
    wire       dv_sync    = sync2_reg[11];
    wire       crs_sync   = sync2_reg[12];

    logic clav_s1_reg;
    logic clav_s2_reg;
    always_ff @(posedge mclk_i) begin
        clav_s1_reg <= rxclav_pin_i;
        clav_s2_reg <= clav_s1_reg;
    end

    wire utopia_on  = chan_enable_i && !mii_mode_i;
    wire slave_on   = utopia_on && utopia_slave_i;
    wire master_on  = utopia_on && !utopia_slave_i;

    // ==========================================================
    // slave receive: cell store and drive toward the master
    logic [7:0] cell_mem [CELL_LEN];
    logic [5:0] wr_idx_reg;
    logic [5:0] rd_idx_reg;
    logic       full_reg;
    logic       drive_reg;
    logic       rxsoc_reg;
    logic [7:0] rxd_reg;

    wire load_fire = cell_load_valid_i && cell_load_ready_o;
    wire send_fire = slave_on && full_reg && rxenb_sync;
    wire wr_last   = (wr_idx_reg == CELL_LAST);
    wire rd_last   = (rd_idx_reg == CELL_LAST);
    assign cell_load_ready_o = slave_on && !full_reg;

    always_ff @(posedge mclk_i) begin
        if (load_fire) begin
            cell_mem[wr_idx_reg] <= cell_load_i.octet;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || !slave_on) begin
            wr_idx_reg <= CELL_FIRST;
            rd_idx_reg <= CELL_FIRST;
            full_reg   <= 1'b0; // R12
            drive_reg  <= 1'b0;
            rxsoc_reg  <= 1'b0;
            rxd_reg    <= IDLE_HDR_ZERO;
        end else begin
            drive_reg <= send_fire; // R10
            rxsoc_reg <= send_fire && (rd_idx_reg == CELL_FIRST); // R1
            if (send_fire) begin
                rxd_reg    <= cell_mem[rd_idx_reg];
                rd_idx_reg <= rd_last ? CELL_FIRST : rd_idx_reg + 6'h01; // R6
            end
            if (load_fire) begin
                wr_idx_reg <= wr_last ? CELL_FIRST : wr_idx_reg + 6'h01;
            end
            if (load_fire && wr_last) begin
                full_reg <= 1'b1; // R2
            end else if (send_fire && rd_last) begin
                full_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // master receive: enable toward phy, capture after the enable
    logic                   rxenb_reg;
    logic [RX_PIPE_LEN-1:0] enb_pipe_reg;
    cell_byte_t             recv_reg;
    logic                   recv_valid_reg;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || !master_on) begin
            rxenb_reg      <= 1'b0;
            enb_pipe_reg   <= '0;
            recv_reg       <= '0;
            recv_valid_reg <= 1'b0;
        end else begin
            rxenb_reg      <= clav_s2_reg; // R3
            enb_pipe_reg   <= {enb_pipe_reg[RX_PIPE_LEN-2:0], rxenb_reg};
            recv_valid_reg <= enb_pipe_reg[RX_PIPE_LEN-1]; // R10
            if (enb_pipe_reg[RX_PIPE_LEN-1]) begin
                recv_reg <= '{soc: soc_sync, octet: rxd_sync};
            end
        end
    end

    assign rxenb_o           = rxenb_reg;
    assign rxenb_oe_o        = master_on;
    assign rxclav_o          = full_reg; // R2
    assign rxclav_oe_o       = slave_on;
    assign rxd_o             = rxd_reg;
    assign rxd_oe_o          = drive_reg;
    assign rxsoc_o           = rxsoc_reg;
    assign rxsoc_oe_o        = slave_on;
    assign cell_recv_o       = recv_reg;
    assign cell_recv_valid_o = recv_valid_reg;

    // ==========================================================
    // transmit: user cells or idle cells, 53 octets each
    tx_state_t  tx_state_reg;
    tx_state_t  tx_state_next;
    logic [5:0] tx_cnt_reg;
    logic [7:0] txd_reg;
    logic       txsoc_reg;
    logic       txenb_reg;

    wire tx_cnt_last = (tx_cnt_reg == CELL_LAST);
    wire tx_user_go  = (tx_state_reg == TX_USER_CELL) && tx_valid_i;
    wire tx_idle_go  = (tx_state_reg == TX_IDLE_CELL);
    wire tx_emit     = tx_user_go || tx_idle_go;
    wire [7:0] idle_octet = (tx_cnt_reg == IDLE_HEC_IDX) ? IDLE_HEC :
                            (tx_cnt_reg == IDLE_PTI_IDX) ? IDLE_HDR_LAST :
                            (tx_cnt_reg <  IDLE_PTI_IDX) ? IDLE_HDR_ZERO : IDLE_FILL;
    wire tx_pick_user = tx_valid_i;
    wire tx_user_starve = (tx_state_reg == TX_USER_CELL) && (tx_cnt_reg == CELL_FIRST) &&
                          !tx_valid_i;
    assign tx_ready_o = (tx_state_reg == TX_USER_CELL);

    always_comb begin
        tx_state_next = tx_state_reg;
        unique case (tx_state_reg)
            TX_OFF: begin
                tx_state_next = tx_pick_user ? TX_USER_CELL : TX_IDLE_CELL; // R5
            end
            TX_IDLE_CELL, TX_USER_CELL: begin
                if (tx_emit && tx_cnt_last) begin
                    tx_state_next = tx_pick_user ? TX_USER_CELL : TX_IDLE_CELL; // R5
                end else if (tx_user_starve) begin
                    tx_state_next = TX_IDLE_CELL; // R5
                end
            end
            default: tx_state_next = TX_OFF;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || !utopia_on) begin
            tx_state_reg <= TX_OFF; // R12
            tx_cnt_reg   <= CELL_FIRST;
            txd_reg      <= IDLE_HDR_ZERO;
            txsoc_reg    <= 1'b0;
            txenb_reg    <= 1'b0;
        end else begin
            tx_state_reg <= tx_state_next;
            txenb_reg    <= tx_emit;
            txsoc_reg    <= tx_emit && (tx_cnt_reg == CELL_FIRST);
            if (tx_emit) begin
                txd_reg    <= tx_user_go ? tx_byte_i : idle_octet; // R4
                tx_cnt_reg <= tx_cnt_last ? CELL_FIRST : tx_cnt_reg + 6'h01; // R6
            end
        end
    end

    assign txd_o   = txd_reg;
    assign txsoc_o = txsoc_reg;
    assign txenb_o = txenb_reg;

    // ==========================================================
    // mii receive status
    logic mii_valid_reg;
    logic mii_error_reg;
    logic mii_broken_reg;
    wire  mii_on = chan_enable_i && mii_mode_i;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || !mii_on) begin
            mii_valid_reg  <= 1'b0;
            mii_error_reg  <= 1'b0;
            mii_broken_reg <= 1'b0;
        end else begin
            mii_valid_reg  <= dv_sync; // R7
            mii_error_reg  <= dv_sync && er_sync; // R9
            mii_broken_reg <= crs_sync && !dv_sync; // R8 R11
        end
    end

    assign mii_rx_valid_o      = mii_valid_reg;
    assign mii_rx_error_o      = mii_error_reg;
    assign mii_broken_header_o = mii_broken_reg;

    // ==========================================================
    // assertions
    a_soc_first_only: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // R1
        rxsoc_o |-> rxd_oe_o && $past(rd_idx_reg) == CELL_FIRST)
        else $error("start of cell not on first octet");
    a_clav_after_load: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // R2
        (load_fire && wr_last && slave_on) ##1 slave_on |-> rxclav_o)
        else $error("cell available missing after full cell");
    a_drive_after_enb: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // R10
        rxd_oe_o |-> $past(rxenb_sync) && $past(full_reg))
        else $error("receive data driven without enable");
    a_master_enb_clav: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // R3
        master_on && $past(master_on) && rxenb_o |-> $past(clav_s2_reg))
        else $error("receive enable without cell available");
    a_tx_cell_length: assert property (@(posedge mclk_i) disable iff (!reset_n_i || !utopia_on) // R6
        txsoc_o && tx_idle_go |-> ##1 (!txsoc_o && txenb_o) [*8])
        else $error("idle cell start repeats too early");
    a_idle_hec_octet: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // R5
        tx_idle_go && tx_cnt_reg == IDLE_HEC_IDX && utopia_on |=> txd_o == IDLE_HEC)
        else $error("idle cell header check octet wrong");
    a_tx_user_data: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // R4
        tx_user_go && utopia_on |=> txd_o == $past(tx_byte_i) && txenb_o)
        else $error("transmit octet not carried through");
    a_broken_header: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // R8
        mii_on && $past(mii_on) && $past(crs_sync) && !$past(dv_sync) |-> mii_broken_header_o)
        else $error("broken header not flagged");
    a_reset_quiet: assert property (@(posedge mclk_i) // R12
        !reset_n_i ##1 1'b1 |-> !rxsoc_o && !rxclav_o && !txenb_o && !txsoc_o)
        else $error("outputs active after reset");
endmodule // cell_link_port

// File: phy_cell_source.sv
// far-side utopia phy model holding one receive cell
`timescale 1ns/10ps
module phy_cell_source (
    input  wire logic       mclk_i,
    input  wire logic       load_i,
    input  wire logic [7:0] base_i,
    input  wire logic       rxenb_i,
    output logic            rxclav_o,
    output logic [7:0]      rxd_o = 8'h00,
    output logic            rxsoc_o = 1'b0
);
    int idx = 53;

    // ==========================================
    // cell source
    assign rxclav_o = (idx < 53);
    always @(posedge mclk_i) begin
        if (load_i) begin
            idx <= 0;
        end else if (rxenb_i && idx < 53) begin
            rxd_o   <= base_i + 8'(idx * 7);
            rxsoc_o <= (idx == 0);
            idx     <= idx + 1;
        end else begin
            // released bus: inverse of last value
            rxd_o   <= ~rxd_o;
            rxsoc_o <= ~rxsoc_o;
        end
    end
endmodule // phy_cell_source

// File: cell_link_port_tb_top.sv
// self-checking bench for the cell link port
`timescale 1ns/10ps
module cell_link_port_tb_top;
    import cell_link_pkg::*;
    logic       mclk_i = 0, reset_n_i = 0, chan_enable_i = 0;
    logic       utopia_slave_i = 0, mii_mode_i = 0, cell_load_valid_i = 0;
    logic       tx_valid_i = 0, crs_pin_i = 0, rx_dv_pin_i = 0, rx_er_pin_i = 0;
    logic       host_enb = 0, phy_load = 0;
    logic [7:0] tx_byte_i = 8'h00, phy_base = 8'h00;
    logic [1:0] sel = 2'd0;
    cell_byte_t cell_load_i = '0;
    cell_byte_t cell_recv_o;
    logic       cell_load_ready_o, cell_recv_valid_o, rxenb_o, rxenb_oe_o, rxclav_o;
    logic       rxclav_oe_o, rxd_oe_o, rxsoc_o, rxsoc_oe_o, tx_ready_o, txsoc_o, txenb_o;
    logic       mii_rx_valid_o, mii_rx_error_o, mii_broken_header_o, phy_clav, phy_soc;
    logic [7:0] rxd_o, txd_o, phy_rxd;
    int         num_errors = 0, cmp_count = 0, seed = 32'h937b, t;
    int         exp_q[$];

    // two-way pin levels from all drivers
    wire logic       rxenb_pin_i  = rxenb_oe_o ? rxenb_o : host_enb;
    wire logic       rxclav_pin_i = rxclav_oe_o ? rxclav_o : phy_clav;
    wire logic [7:0] rxd_pin_i    = rxd_oe_o ? rxd_o : phy_rxd;
    wire logic       rxsoc_pin_i  = rxsoc_oe_o ? rxsoc_o : phy_soc;
    wire cell_byte_t mon = sel == 2'd0 ? cell_byte_t'({txsoc_o, txd_o}) :
                           sel == 2'd1 ? cell_byte_t'({rxsoc_o, rxd_o}) : cell_recv_o;
    wire logic       mon_v = sel == 2'd0 ? txenb_o : sel == 2'd1 ? rxd_oe_o : cell_recv_valid_o;

    cell_link_port dut (
        .mclk_i, .reset_n_i, .chan_enable_i, .utopia_slave_i, .mii_mode_i, .cell_load_i,
        .cell_load_valid_i, .cell_load_ready_o, .cell_recv_o, .cell_recv_valid_o,
        .rxenb_pin_i, .rxenb_o, .rxenb_oe_o, .rxclav_pin_i, .rxclav_o, .rxclav_oe_o,
        .rxd_pin_i, .rxd_o, .rxd_oe_o, .rxsoc_pin_i, .rxsoc_o, .rxsoc_oe_o, .tx_byte_i,
        .tx_valid_i, .tx_ready_o, .txd_o, .txsoc_o, .txenb_o, .crs_pin_i, .rx_dv_pin_i,
        .rx_er_pin_i, .mii_rx_valid_o, .mii_rx_error_o, .mii_broken_header_o
    );
    phy_cell_source phy (
        .mclk_i, .load_i(phy_load), .base_i(phy_base), .rxenb_i(rxenb_pin_i),
        .rxclav_o(phy_clav), .rxd_o(phy_rxd), .rxsoc_o(phy_soc)
    );

    initial forever #2 mclk_i = ~mclk_i;

    // ==========================================
    // helpers
    task automatic test_done();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic fail(string m);
        num_errors++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic timed_out(bit ok);
        if (!ok) begin
            fail("wait bound used up");
            test_done();
        end
    endtask
    task automatic cmp_octet(cell_byte_t got, cell_byte_t exp);
        cmp_count++;
        if (got !== exp) fail($sformatf("octet got %h exp %h", got, exp));
    endtask
    task automatic cmp_flag(logic got, logic exp);
        cmp_count++;
        if (got !== exp) fail($sformatf("flag got %b exp %b", got, exp));
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic check_cell(bit need_soc);
        int k;
        k = 0;
        for (int w = 0; k < CELL_OCTETS; w++) begin
            tick(1);
            timed_out(w < 600);
            if (mon_v && (k > 0 || !need_soc || mon.soc)) begin
                cmp_octet(mon, cell_byte_t'({k == 0, 8'(exp_q[k])}));
                k++;
            end
        end
    endtask

    // ==========================================
    // scenarios
    initial begin
        tick(5);
        cmp_flag(txenb_o | rxsoc_o | rxclav_o | cell_recv_valid_o, 1'b0);
        reset_n_i = 1;
        tick(4);
        cmp_flag(txenb_o, 1'b0);
        chan_enable_i = 1;
        exp_q = {0, 0, 0, 1, 'h52};
        repeat (48) exp_q.push_back('h6a);
        check_cell(1);
        exp_q = {};
        tx_valid_i = 1;
        tx_byte_i = 8'($random(seed));
        for (t = 0; t < 200 && !tx_ready_o; t++) tick(1);
        timed_out(tx_ready_o === 1'b1);
        fork
            check_cell(1);
            repeat (CELL_OCTETS) begin
                exp_q.push_back(tx_byte_i);
                tick(1);
                tx_byte_i = 8'($random(seed));
            end
        join_any
        tx_valid_i = 0;
        wait fork;
        exp_q = {0, 0, 0, 1, 'h52};
        repeat (48) exp_q.push_back('h6a);
        check_cell(1);
        utopia_slave_i = 1;
        exp_q = {};
        tick(2);
        cmp_flag(rxclav_oe_o, 1'b1);
        cmp_flag(rxsoc_oe_o, 1'b1);
        cell_load_valid_i = 1;
        repeat (CELL_OCTETS) begin
            cell_load_i = cell_byte_t'({1'b0, 8'($random(seed))});
            cmp_flag(rxclav_o, 1'b0);
            cmp_flag(cell_load_ready_o, 1'b1);
            exp_q.push_back(cell_load_i.octet);
            tick(1);
        end
        cell_load_valid_i = 0;
        tick(2);
        cmp_flag(rxclav_o, 1'b1);
        cmp_flag(cell_load_ready_o, 1'b0);
        host_enb = 1;
        sel = 2'd1;
        check_cell(0);
        host_enb = 0;
        tick(1);
        cmp_flag(rxclav_o, 1'b0);
        utopia_slave_i = 0;
        exp_q = {};
        phy_base = 8'($random(seed));
        for (int k = 0; k < CELL_OCTETS; k++) exp_q.push_back((phy_base + k * 7) & 255);
        tick(6);
        cmp_flag(rxenb_oe_o, 1'b1);
        cmp_flag(rxenb_o, 1'b0);
        sel = 2'd2;
        phy_load = 1;
        tick(1);
        phy_load = 0;
        check_cell(0);
        mii_mode_i = 1;
        for (int i = 0; i < 8; i++) begin
            {crs_pin_i, rx_dv_pin_i, rx_er_pin_i} = 3'(i);
            tick(4);
            cmp_flag(mii_broken_header_o, i[2] & !i[1]);
            cmp_flag(mii_rx_valid_o, i[1]);
            cmp_flag(mii_rx_error_o, i[1] & i[0]);
        end
        test_done();
    end
endmodule // cell_link_port_tb_top
